// *** hw/dsw_watchdog.sv ***
// default-start watchdog: write-once mode register, restart key register, overflow outputs
// assumes a byte register port from the cpu and a subclock arriving from a pin
`timescale 1ns/1ps
`include "dsw_params.svh"

// Behaviour
// - the mode register takes one whole byte write after reset and may be read at will.
// - reset loads the mode register with 67H.
// - mode bits 6:5 decode 00 stop, 01 interrupt request, 1x internal reset on overflow.
// - a second mode register write forces an overflow at once.
// - writing 1FH to the mode register stops the watchdog.
// - the five-bit select chooses 2^18..2^25 system clocks, 2^9..2^16 subclocks, or stop.
// - writing ACH to the restart register clears the counter and counting restarts at zero.
// - the restart register reads 9AH always.
// - any other restart register value forces an overflow at once.
// - a single-bit write to the restart register forces an overflow.
// - after reset the watchdog counts in reset mode with the reset interval.
// - once configured nothing but a device reset stops the watchdog.
// - on overflow the reset or interrupt output fires as the mode field says.
// - the default is reset mode with a 2^25 system clock interval.
module dsw_watchdog
    import dsw_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic subClock,
    input wire logic [31:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic regBitOp,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    output logic overflowNmiRequest,
    output logic overflowInternalReset
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [`DSW_CNT_W-1:0] limitFor(input logic [4:0] sel);
        logic [4:0] expo;
        // table form keeps each code's exponent visible at a glance
        case (sel[3:0])
            4'h0: expo = 5'(`DSW_MAIN_EXP_BASE);
            4'h1: expo = 5'(`DSW_MAIN_EXP_BASE + 1);
            4'h2: expo = 5'(`DSW_MAIN_EXP_BASE + 2);
            4'h3: expo = 5'(`DSW_MAIN_EXP_BASE + 3);
            4'h4: expo = 5'(`DSW_MAIN_EXP_BASE + 4);
            4'h5: expo = 5'(`DSW_MAIN_EXP_BASE + 5);
            4'h6: expo = 5'(`DSW_MAIN_EXP_BASE + 6);
            4'h7: expo = 5'(`DSW_MAIN_EXP_BASE + 7);
            4'h8: expo = 5'(`DSW_SUB_EXP_BASE);
            4'h9: expo = 5'(`DSW_SUB_EXP_BASE + 1);
            4'hA: expo = 5'(`DSW_SUB_EXP_BASE + 2);
            4'hB: expo = 5'(`DSW_SUB_EXP_BASE + 3);
            4'hC: expo = 5'(`DSW_SUB_EXP_BASE + 4);
            4'hD: expo = 5'(`DSW_SUB_EXP_BASE + 5);
            4'hE: expo = 5'(`DSW_SUB_EXP_BASE + 6);
            4'hF: expo = 5'(`DSW_SUB_EXP_BASE + 7);
            default: expo = 5'(`DSW_MAIN_EXP_BASE);
        endcase
        limitFor = `DSW_CNT_W'(1) << expo;
    endfunction

    function automatic dsw_mode_e modeOf(input dsw_byte_t cfg);
        if (cfg[`DSW_OPMODE_HI]) begin
            modeOf = DSW_RESET;
        end else if (cfg[`DSW_OPMODE_LO]) begin
            modeOf = DSW_NMI;
        end else begin
            modeOf = DSW_STOPPED;
        end
    endfunction

    // a restart counts only as a whole-byte write of the key value
    function automatic logic keyIsGood(input dsw_byte_t data, input logic bitOp);
        keyIsGood = !bitOp && (data == `DSW_KEY_VALUE);
    endfunction

    // the select msb halts counting whatever the mode field says
    function automatic logic cfgRuns(input dsw_byte_t cfg);
        cfgRuns = (modeOf(cfg) != DSW_STOPPED) && !cfg[`DSW_SEL_MSB];
    endfunction

    // address compare used by the write decode; the read decode compares regAddr directly
    function automatic logic addrIs(input logic [31:0] addr, input logic [31:0] offset);
        addrIs = (addr == offset);
    endfunction

    // ----------------------------------------------------------------
    // register access decode
    // ----------------------------------------------------------------
    logic modeHit;
    logic keyHit;
    assign modeHit = regWrite && addrIs(regAddr, `DSW_MODE_OFFSET);
    assign keyHit = regWrite && addrIs(regAddr, `DSW_KEY_OFFSET);

    // ----------------------------------------------------------------
    // subclock synchroniser and edge
    // ----------------------------------------------------------------
    logic [2:0] subSync_q;
    logic [2:0] subSync_d;
    logic subLevel_q;
    logic subLevel_d;
    logic subTick;

    always_comb begin
        subSync_d = {subSync_q[1:0], subClock};
        subLevel_d = subLevel_q;
        // change counts once the second and third stages agree
        // the subclock is far slower than clk, so no edge is lost here
        if (subSync_q[1] == subSync_q[2]) begin
            subLevel_d = subSync_q[2];
        end
    end
    assign subTick = subLevel_d && !subLevel_q;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            subSync_q <= 3'h0;
            subLevel_q <= 1'b0;
        end else begin
            subSync_q <= subSync_d;
            subLevel_q <= subLevel_d;
        end
    end

    // ----------------------------------------------------------------
    // mode register and counter
    // ----------------------------------------------------------------
    // limitation: a forced overflow in a stopped watchdog leaves as a reset,
    // since no mode field is left to route it; the key register has no storage,
    // only its write strobe and data matter
    dsw_byte_t modeCfg_q;
    dsw_byte_t modeCfg_d;
    logic written_q;
    logic written_d;
    logic [`DSW_CNT_W-1:0] count_q;
    logic [`DSW_CNT_W-1:0] count_d;
    logic forceOvf;
    logic modeRewrite;
    logic keyWrong;
    logic keyBitOp;
    logic running;
    logic countTick;
    logic expire;
    logic nmiOut_q;
    logic nmiOut_d;
    logic rstOut_q;
    logic rstOut_d;
    dsw_byte_t rdata_q;
    dsw_byte_t rdata_d;

    // stop when select msb set or mode field zero
    // msb of the select halts counting
    assign running = cfgRuns(modeCfg_q);
    assign countTick = modeCfg_q[`DSW_SEL_SUB] ? subTick : 1'b1;
    // overflow at the power of two
    assign expire = running && countTick && (count_q == limitFor(modeCfg_q[4:0]) - 1'b1);

    // ----------------------------------------------------------------
    // forced overflow sources
    // ----------------------------------------------------------------
    // second mode write
    assign modeRewrite = modeHit && written_q;
    assign keyWrong = keyHit && !regBitOp && (regWdata != `DSW_KEY_VALUE);
    // bit op on the key register
    assign keyBitOp = keyHit && regBitOp;
    assign forceOvf = modeRewrite || keyWrong || keyBitOp;

    // ----------------------------------------------------------------
    // mode register next value
    // ----------------------------------------------------------------
    always_comb begin
        modeCfg_d = modeCfg_q;
        written_d = written_q;
        // first byte write only; bit writes are not accepted
        if (modeHit && !written_q) begin
            written_d = 1'b1;
            if (!regBitOp) begin
                // bit 7 reads as zero whatever was written
                modeCfg_d = {1'b0, regWdata[6:0]};
            end
        end
    end

    // ----------------------------------------------------------------
    // counter next value
    // ----------------------------------------------------------------
    // on the subclock the count moves on synchronised edges only;
    // on the system clock it moves every cycle
    always_comb begin
        count_d = count_q;
        if (keyHit && keyIsGood(regWdata, regBitOp)) begin
            count_d = '0;
        end else if (expire) begin
            // counting carries on after a timeout, from zero
            count_d = '0;
        end else if (running && countTick) begin
            count_d = count_q + 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // overflow routing
    // ----------------------------------------------------------------
    // route overflow by the mode field; forced overflows share the path
    always_comb begin
        nmiOut_d = 1'b0;
        rstOut_d = 1'b0;
        if (expire || forceOvf) begin
            case (modeOf(modeCfg_q))
                DSW_NMI: nmiOut_d = 1'b1;
                DSW_RESET: rstOut_d = 1'b1;
                // a stopped watchdog still reports forced errors as a reset
                default: rstOut_d = forceOvf;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    // key register always reads back its fixed value
    always_comb begin
        rdata_d = rdata_q;
        if (regRead) begin
            if (regAddr == `DSW_MODE_OFFSET) begin
                rdata_d = modeCfg_q;
            end else if (regAddr == `DSW_KEY_OFFSET) begin
                rdata_d = `DSW_KEY_RESET;
            end else begin
                rdata_d = 8'h00;
            end
        end
    end

    // ----------------------------------------------------------------
    // state registers
    // ----------------------------------------------------------------
    // reset value starts reset mode at 2^25
    // only reset returns the block to its writable state
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            modeCfg_q <= `DSW_MODE_RESET;
            written_q <= 1'b0;
        end else begin
            modeCfg_q <= modeCfg_d;
            written_q <= written_d;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    // overflow pulses leave straight from flops, one cycle wide,
    // so a glitch on the decode never reaches the reset tree
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            nmiOut_q <= 1'b0;
            rstOut_q <= 1'b0;
        end else begin
            nmiOut_q <= nmiOut_d;
            rstOut_q <= rstOut_d;
        end
    end

    // read data holds between reads
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign regRdata = rdata_q;
    assign overflowNmiRequest = nmiOut_q;
    assign overflowInternalReset = rstOut_q;

endmodule // dsw_watchdog

// *** inc/dsw_params.svh ***
// constants for the default-start watchdog: register offsets, reset values, field positions
// assumes a byte-wide register port inside the device and a 100 MHz system clock
`ifndef DSW_PARAMS_SVH
`define DSW_PARAMS_SVH

`define DSW_MODE_OFFSET 32'hFFFFF6D0
`define DSW_KEY_OFFSET 32'hFFFFF6D1
`define DSW_MODE_RESET 8'h67
`define DSW_KEY_RESET 8'h9A
`define DSW_KEY_VALUE 8'hAC
`define DSW_STOP_VALUE 8'h1F
`define DSW_OPMODE_HI 6
`define DSW_OPMODE_LO 5
`define DSW_SEL_MSB 4
`define DSW_SEL_SUB 3
`define DSW_MAIN_EXP_BASE 18
`define DSW_SUB_EXP_BASE 9
`define DSW_CNT_W 26
`define DSW_SYNC_STAGES 3

`endif

// *** inc/dsw_pkg.sv ***
// types for the default-start watchdog
// assumes dsw_params.svh carries every number
package dsw_pkg;
    typedef enum logic [1:0] {
        DSW_STOPPED = 2'b00,
        DSW_NMI = 2'b01,
        DSW_RESET = 2'b10
    } dsw_mode_e;
    typedef logic [7:0] dsw_byte_t;
endpackage

// *** test/dsw_watchdog_properties.sv ***
// checker for the default-start watchdog port timing
// assumes the dsw_watchdog top ports
`timescale 1ns/1ps
`include "dsw_params.svh"
module dsw_checker
    import dsw_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic subClock,
    input wire logic [31:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic regBitOp,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    input wire logic overflowNmiRequest,
    input wire logic overflowInternalReset
);
    logic modeWritten_q, keyHit, modeHit, fire;
    dsw_byte_t mode_q;
    assign keyHit = regWrite && regAddr == `DSW_KEY_OFFSET;
    assign modeHit = regWrite && regAddr == `DSW_MODE_OFFSET;
    assign fire = overflowNmiRequest || overflowInternalReset;
    // shadow of the accepted mode byte; a bit access burns the write unchanged
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            modeWritten_q <= 1'b0;
            mode_q <= `DSW_MODE_RESET;
        end else if (modeHit && !modeWritten_q) begin
            modeWritten_q <= 1'b1;
            mode_q <= regBitOp ? mode_q : (regWdata & 8'h7F);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_mode_read_back: assert property (regRead && regAddr == `DSW_MODE_OFFSET |=>
        regRdata == mode_q) else $error("mode read wrong");
    a_key_read_fixed: assert property (regRead && regAddr == `DSW_KEY_OFFSET |=>
        regRdata == `DSW_KEY_RESET) else $error("key read wrong");
    a_bad_key_fires: assert property (keyHit && !regBitOp && regWdata != `DSW_KEY_VALUE
        |=> fire) else $error("wrong key no overflow");
    a_bitop_key_fires: assert property (keyHit && regBitOp |=> fire)
        else $error("bit access no overflow");
    a_second_mode_fires: assert property (modeHit && modeWritten_q |=> fire)
        else $error("second mode write no overflow");
    a_good_key_quiet: assert property (keyHit && !regBitOp && regWdata == `DSW_KEY_VALUE
        |-> ##2 !fire) else $error("overflow after restart");
    a_nmi_route: assert property (overflowNmiRequest |-> mode_q[6:5] == 2'b01)
        else $error("nmi in wrong mode");
    a_reset_route: assert property (overflowInternalReset |-> mode_q[6:5] != 2'b01)
        else $error("reset in nmi mode");
    a_single_output: assert property (!(overflowNmiRequest && overflowInternalReset))
        else $error("both outputs high");
    cover property (overflowNmiRequest);
    cover property (overflowInternalReset);
    cover property (modeHit && modeWritten_q);
endmodule // dsw_checker
bind dsw_watchdog dsw_checker chk_u (.clk(clk), .reset(reset), .subClock(subClock),
    .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regBitOp(regBitOp),
    .regWdata(regWdata), .regRdata(regRdata), .overflowNmiRequest(overflowNmiRequest),
    .overflowInternalReset(overflowInternalReset));

// *** test/dsw_watchdog_tb.sv ***
// self-checking bench for the default-start watchdog
// assumes subclock of 4 system clocks, select 08 gives 2^9 ticks
`timescale 1ns/1ps
`include "dsw_params.svh"
module dsw_watchdog_tb;
    import dsw_pkg::*;
    logic clk, reset, subClock, regWrite, regRead, regBitOp, subEn;
    logic [31:0] regAddr;
    dsw_byte_t regWdata, regRdata, got;
    logic overflowNmiRequest, overflowInternalReset;
    int errors, n_tests, seed, k, t0;
    int nmiCnt = 0;
    int rstCnt = 0;
    int cyc = 0;
    dsw_watchdog dut_u (.clk(clk), .reset(reset), .subClock(subClock), .regAddr(regAddr),
        .regWrite(regWrite), .regRead(regRead), .regBitOp(regBitOp), .regWdata(regWdata),
        .regRdata(regRdata), .overflowNmiRequest(overflowNmiRequest),
        .overflowInternalReset(overflowInternalReset));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // pulse counters cleared by reset; the ceiling cuts a hang short
    always @(posedge clk) begin
        cyc <= cyc + 1;
        nmiCnt <= reset ? 0 : nmiCnt + overflowNmiRequest;
        rstCnt <= reset ? 0 : rstCnt + overflowInternalReset;
        if (reset) begin
            subClock <= 1'b0;
        end else if (subEn && cyc % 2 == 0) begin
            subClock <= ~subClock;
        end
        if (cyc == 40000) begin
            errors++;
            end_sim();
        end
    end
    // clocks to a subclock timeout: 2^(9+n) ticks, one tick per four clocks
    function automatic int subTimeout(input logic [2:0] n);
        return (1 << (`DSW_SUB_EXP_BASE + n)) * 4;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic wr, input logic [31:0] a, input dsw_byte_t d, input logic b);
        regAddr <= a;
        regWdata <= d;
        regBitOp <= b;
        regWrite <= wr;
        regRead <= ~wr;
        @(posedge clk);
        regWrite <= 1'b0;
        regRead <= 1'b0;
        regBitOp <= 1'b0;
        #1 got = regRdata;
        repeat (2) @(posedge clk);
    endtask
    task automatic do_reset();
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
    endtask
    task automatic end_sim();
        $display("tests=%0d errors=%0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        {errors, n_tests} = '0;
        seed = 32'hceaf;
        {regWrite, regRead, regBitOp, subEn, regAddr, regWdata} = '0;
        reset = 1'b1;
        @(posedge clk);
        do_reset();
        acc(1'b0, `DSW_MODE_OFFSET, 8'h00, 1'b0); chk(got, 8'h67);
        acc(1'b0, `DSW_KEY_OFFSET, 8'h00, 1'b0); chk(got, 8'h9A);
        acc(1'b0, 32'hFFFFF6D4, 8'h00, 1'b0); chk(got, 8'h00);
        for (k = 0; k < 4; k++) begin
            acc(1'b1, `DSW_KEY_OFFSET, 8'hAC ^ (8'h01 | 8'($random(seed))), 1'b0);
            chk(rstCnt, k + 1);
        end
        acc(1'b1, `DSW_KEY_OFFSET, 8'hAC, 1'b1); chk(rstCnt, 5);
        chk(nmiCnt, 0);
        do_reset();
        subEn <= 1'b1;
        acc(1'b1, `DSW_MODE_OFFSET, 8'h28, 1'b0);
        acc(1'b0, `DSW_MODE_OFFSET, 8'h00, 1'b0); chk(got, 8'h28);
        for (k = 0; k < 3; k++) begin
            repeat (1500) @(posedge clk);
            acc(1'b1, `DSW_KEY_OFFSET, 8'hAC, 1'b0);
        end
        chk(nmiCnt + rstCnt, 0);
        t0 = cyc;
        while (nmiCnt == 0 && cyc < t0 + 3000) @(posedge clk);
        chk(cyc - t0 > subTimeout(3'h0) - 60 && cyc - t0 < subTimeout(3'h0) + 30, 1);
        chk(rstCnt, 0);
        acc(1'b1, `DSW_MODE_OFFSET, 8'h1F, 1'b0); chk(nmiCnt, 2);
        acc(1'b0, `DSW_MODE_OFFSET, 8'h00, 1'b0); chk(got, 8'h28);
        do_reset();
        acc(1'b1, `DSW_MODE_OFFSET, 8'h1F, 1'b0);
        repeat (3000) @(posedge clk);
        chk(nmiCnt + rstCnt, 0);
        acc(1'b1, `DSW_KEY_OFFSET, 8'h00, 1'b0); chk(rstCnt, 1);
        do_reset();
        acc(1'b1, `DSW_MODE_OFFSET, 8'h48, 1'b0);
        t0 = cyc;
        while (rstCnt == 0 && cyc < t0 + 3000) @(posedge clk);
        chk(rstCnt, 1);
        chk(nmiCnt, 0);
        end_sim();
    end
endmodule // dsw_watchdog_tb
